// ==== src/geei_pkg.sv ====
package geei_pkg;

	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int PIN_COUNT = 16;
	localparam int BANK_W = 8;
	localparam int SEL_W = 2;
	localparam int PINS_PER_SEL_REG = 4;
	localparam int ADDR_W = 8;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_IRQ_MASK_HIGH_BANK = 8'h08;
	localparam logic [7:0] OFS_IRQ_MASK_LOW_BANK = 8'h09;
	localparam logic [7:0] OFS_EDGE_SELECT_PINS_15_12 = 8'h0a;
	localparam logic [7:0] OFS_EDGE_SELECT_PINS_7_4 = 8'h0b;
	localparam logic [7:0] OFS_EDGE_SELECT_PINS_11_8 = 8'h0c;
	localparam logic [7:0] OFS_EDGE_SELECT_PINS_3_0 = 8'h0d;
	localparam logic [7:0] OFS_IRQ_SOURCE_HIGH_BANK = 8'h0e;
	localparam logic [7:0] OFS_IRQ_SOURCE_LOW_BANK = 8'h0f;
	localparam logic [7:0] OFS_EVENT_FLAGS_HIGH_BANK = 8'h10;
	localparam logic [7:0] OFS_EVENT_FLAGS_LOW_BANK = 8'h11;

	// ----------------------------------------
	// First pin of each edge selector register
	// ----------------------------------------
	localparam int BASE_PINS_15_12 = 12;
	localparam int BASE_PINS_11_8 = 8;
	localparam int BASE_PINS_7_4 = 4;
	localparam int BASE_PINS_3_0 = 0;

	// ----------------------------------------
	// Edge selector codes
	// ----------------------------------------
	localparam logic [1:0] SEL_NONE = 2'h0;
	localparam logic [1:0] SEL_RISE = 2'h1;
	localparam logic [1:0] SEL_FALL = 2'h2;
	localparam logic [1:0] SEL_BOTH = 2'h3;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] RST_MASK_BANK = 8'hff;
	localparam logic [7:0] RST_EDGE_SELECT = 8'h00;
	localparam logic [7:0] RST_FLAGS_BANK = 8'h00;
	localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

endpackage : geei_pkg

// ==== src/geei_top.sv ====
`timescale 1ns/10ps
// Summary of operation
// - Two-bit selector: none, rising, falling, both
// - Register 0x0B holds pins 7 to 4
// - Register 0x0C holds pins 11 to 8
// - Register 0x0D holds pins 3 to 0
// - Unmasked selected edge sets interrupt-source bit
// - Writing one to source clears source and flag
// - Interrupt released only when all sources clear
// - Selected edge always sets sticky event flag
// - Writing one to flag clears flag and source
// - Changing a pin's selector clears its flag
// - Mask one blocks interrupt; masks reset high
// - Register 0x0B holds pin 7 in 7:6
// - Register 0x0A holds pins 15 to 12
module geei_top (
	input wire logic CLK_I,
	input wire logic RESET_I,
	input wire logic [15:0] IO_I,
	input wire logic [7:0] REG_ADDR_I,
	input wire logic [7:0] REG_WDATA_I,
	input wire logic REG_WE_I,
	output logic [7:0] REG_RDATA_O,
	output logic IRQ_OUT_N_O
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [15:0] sync1;
		logic [15:0] sync2;
		logic [15:0] prev;
		logic [15:0] mask;
		logic [31:0] sense;
		logic [15:0] src;
		logic [15:0] evt;
		logic [7:0] rdata;
		logic irq_n;
	} geei_state_t;

	localparam geei_state_t ST_RESET = '{
		sync1: 16'h0000,
		sync2: 16'h0000,
		prev: 16'h0000,
		mask: {geei_pkg::RST_MASK_BANK, geei_pkg::RST_MASK_BANK},
		sense: {4{geei_pkg::RST_EDGE_SELECT}},
		src: {geei_pkg::RST_FLAGS_BANK, geei_pkg::RST_FLAGS_BANK},
		evt: {geei_pkg::RST_FLAGS_BANK, geei_pkg::RST_FLAGS_BANK},
		rdata: geei_pkg::RDATA_UNMAPPED,
		irq_n: 1'b1
	};

	geei_state_t st_r;
	geei_state_t st_nxt;
	logic [15:0] det;
	logic [15:0] sel_on;

	// ----------------------------------------
	// Decoding functions
	// ----------------------------------------
	function automatic logic [15:0] edge_hits(input logic [15:0] cur, input logic [15:0] prv,
		input logic [31:0] sense);
		logic [15:0] hit;
		hit = 16'h0000;
		for (int i = 0; i < geei_pkg::PIN_COUNT; i++) begin
			unique case (sense[i*geei_pkg::SEL_W +: geei_pkg::SEL_W])
				geei_pkg::SEL_NONE: hit[i] = 1'b0;
				geei_pkg::SEL_RISE: hit[i] = cur[i] & ~prv[i];
				geei_pkg::SEL_FALL: hit[i] = ~cur[i] & prv[i];
				geei_pkg::SEL_BOTH: hit[i] = cur[i] ^ prv[i];
			endcase
		end
		return hit;
	endfunction : edge_hits

	function automatic logic [15:0] sel_enabled(input logic [31:0] sense);
		logic [15:0] en;
		en = 16'h0000;
		for (int i = 0; i < geei_pkg::PIN_COUNT; i++) begin
			en[i] = |sense[i*geei_pkg::SEL_W +: geei_pkg::SEL_W];
		end
		return en;
	endfunction : sel_enabled

	function automatic int sense_base(input logic [7:0] addr);
		int base;
		base = geei_pkg::BASE_PINS_3_0;
		if (addr == geei_pkg::OFS_EDGE_SELECT_PINS_15_12) begin
			base = geei_pkg::BASE_PINS_15_12;
		end else if (addr == geei_pkg::OFS_EDGE_SELECT_PINS_7_4) begin
			base = geei_pkg::BASE_PINS_7_4;
		end else if (addr == geei_pkg::OFS_EDGE_SELECT_PINS_11_8) begin
			base = geei_pkg::BASE_PINS_11_8;
		end
		return base;
	endfunction : sense_base

	assign det = edge_hits(st_r.sync2, st_r.prev, st_r.sense);
	assign sel_on = sel_enabled(st_r.sense);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		int base;
		int p;
		base = 0;
		p = 0;
		st_nxt = st_r;
		st_nxt.sync1 = IO_I;
		st_nxt.sync2 = st_r.sync1;
		st_nxt.prev = st_r.sync2;
		if (REG_WE_I) begin
			unique case (REG_ADDR_I)
				geei_pkg::OFS_IRQ_MASK_HIGH_BANK: begin
					st_nxt.mask[15:8] = REG_WDATA_I;
				end
				geei_pkg::OFS_IRQ_MASK_LOW_BANK: begin
					st_nxt.mask[7:0] = REG_WDATA_I;
				end
				geei_pkg::OFS_EDGE_SELECT_PINS_15_12, geei_pkg::OFS_EDGE_SELECT_PINS_7_4,
				geei_pkg::OFS_EDGE_SELECT_PINS_11_8, geei_pkg::OFS_EDGE_SELECT_PINS_3_0: begin
					base = sense_base(REG_ADDR_I);
					for (int j = 0; j < geei_pkg::PINS_PER_SEL_REG; j++) begin
						p = base + j;
						if (st_r.sense[p*geei_pkg::SEL_W +: geei_pkg::SEL_W] !=
							REG_WDATA_I[j*geei_pkg::SEL_W +: geei_pkg::SEL_W]) begin
							st_nxt.evt[p] = 1'b0;
						end
						st_nxt.sense[p*geei_pkg::SEL_W +: geei_pkg::SEL_W] =
							REG_WDATA_I[j*geei_pkg::SEL_W +: geei_pkg::SEL_W];
					end
				end
				geei_pkg::OFS_IRQ_SOURCE_HIGH_BANK, geei_pkg::OFS_EVENT_FLAGS_HIGH_BANK: begin
					st_nxt.src[15:8] = st_r.src[15:8] & ~REG_WDATA_I;
					st_nxt.evt[15:8] = st_r.evt[15:8] & ~REG_WDATA_I;
				end
				geei_pkg::OFS_IRQ_SOURCE_LOW_BANK, geei_pkg::OFS_EVENT_FLAGS_LOW_BANK: begin
					st_nxt.src[7:0] = st_r.src[7:0] & ~REG_WDATA_I;
					st_nxt.evt[7:0] = st_r.evt[7:0] & ~REG_WDATA_I;
				end
				default: begin
				end
			endcase
		end
		st_nxt.evt = st_nxt.evt | det;
		st_nxt.src = st_nxt.src | (det & ~st_r.mask);
		st_nxt.irq_n = ~|st_nxt.src;
		unique case (REG_ADDR_I)
			geei_pkg::OFS_IRQ_MASK_HIGH_BANK: st_nxt.rdata = st_r.mask[15:8];
			geei_pkg::OFS_IRQ_MASK_LOW_BANK: st_nxt.rdata = st_r.mask[7:0];
			geei_pkg::OFS_EDGE_SELECT_PINS_15_12: st_nxt.rdata = st_r.sense[31:24];
			geei_pkg::OFS_EDGE_SELECT_PINS_7_4: st_nxt.rdata = st_r.sense[15:8];
			geei_pkg::OFS_EDGE_SELECT_PINS_11_8: st_nxt.rdata = st_r.sense[23:16];
			geei_pkg::OFS_EDGE_SELECT_PINS_3_0: st_nxt.rdata = st_r.sense[7:0];
			geei_pkg::OFS_IRQ_SOURCE_HIGH_BANK: st_nxt.rdata = st_r.src[15:8];
			geei_pkg::OFS_IRQ_SOURCE_LOW_BANK: st_nxt.rdata = st_r.src[7:0];
			geei_pkg::OFS_EVENT_FLAGS_HIGH_BANK: st_nxt.rdata = st_r.evt[15:8];
			geei_pkg::OFS_EVENT_FLAGS_LOW_BANK: st_nxt.rdata = st_r.evt[7:0];
			default: st_nxt.rdata = geei_pkg::RDATA_UNMAPPED;
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			st_r <= ST_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign REG_RDATA_O = st_r.rdata;
	assign IRQ_OUT_N_O = st_r.irq_n;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_irq_level: assert property (@(posedge CLK_I) disable iff (RESET_I)
		IRQ_OUT_N_O == (st_r.src == 16'h0000))
		else $error("Interrupt level does not match source bits");

	chk_edge_sets_flag: assert property (@(posedge CLK_I) disable iff (RESET_I)
		(det != 16'h0000) |=> ((st_r.evt & $past(det)) == $past(det)))
		else $error("Detected edge did not set its event flag");

	chk_unmasked_source: assert property (@(posedge CLK_I) disable iff (RESET_I)
		(det != 16'h0000) |=> ((st_r.src & $past(det & ~st_r.mask)) == $past(det & ~st_r.mask)))
		else $error("Unmasked edge did not set its source bit");

	chk_mask_blocks: assert property (@(posedge CLK_I) disable iff (RESET_I)
		((st_r.src & ~$past(st_r.src) & $past(st_r.mask)) == 16'h0000))
		else $error("Masked pin raised a source bit");

	chk_mask_reset: assert property (@(posedge CLK_I) disable iff (RESET_I)
		$past(RESET_I) |-> (st_r.mask == {geei_pkg::RST_MASK_BANK, geei_pkg::RST_MASK_BANK}))
		else $error("Mask not all ones after reset");

	chk_none_no_event: assert property (@(posedge CLK_I) disable iff (RESET_I)
		((st_r.evt & ~$past(st_r.evt) & ~$past(sel_on)) == 16'h0000))
		else $error("Flag set on pin with no edge selected");

	chk_flag_w1c: assert property (@(posedge CLK_I) disable iff (RESET_I)
		(REG_WE_I && REG_ADDR_I == geei_pkg::OFS_EVENT_FLAGS_LOW_BANK && det == 16'h0000)
		|=> ((st_r.evt[7:0] & $past(REG_WDATA_I)) == 8'h00 && (st_r.src[7:0] & $past(REG_WDATA_I)) == 8'h00))
		else $error("Flag write of one did not clear flag and source");

	chk_source_w1c: assert property (@(posedge CLK_I) disable iff (RESET_I)
		(REG_WE_I && REG_ADDR_I == geei_pkg::OFS_IRQ_SOURCE_LOW_BANK && det == 16'h0000)
		|=> ((st_r.src[7:0] & $past(REG_WDATA_I)) == 8'h00 && (st_r.evt[7:0] & $past(REG_WDATA_I)) == 8'h00
		&& (st_r.src[7:0] & ~$past(REG_WDATA_I)) == ($past(st_r.src[7:0]) & ~$past(REG_WDATA_I))))
		else $error("Source write did not clear exactly the written bits");

	chk_select_change: assert property (@(posedge CLK_I) disable iff (RESET_I)
		(REG_WE_I && REG_ADDR_I == geei_pkg::OFS_EDGE_SELECT_PINS_3_0 && det == 16'h0000
		&& REG_WDATA_I[1:0] != st_r.sense[1:0]) |=> !st_r.evt[0])
		else $error("Selector change did not clear the event flag");

	chk_select_map: assert property (@(posedge CLK_I) disable iff (RESET_I)
		(REG_WE_I && REG_ADDR_I == geei_pkg::OFS_EDGE_SELECT_PINS_7_4)
		|=> (st_r.sense[15:14] == $past(REG_WDATA_I[7:6]) && st_r.sense[13:12] == $past(REG_WDATA_I[5:4]))
		##1 (REG_RDATA_O == $past(st_r.sense[15:8]) || $past(REG_ADDR_I) != geei_pkg::OFS_EDGE_SELECT_PINS_7_4))
		else $error("Pins 7 to 4 selector mapping wrong");

	// ----------------------------------------
	// Checks: synchroniser and edge decode
	// ----------------------------------------
	chk_sync_chain: assert property (@(posedge CLK_I) disable iff (RESET_I)
		(st_r.sync2 == $past(st_r.sync1) && st_r.prev == $past(st_r.sync2)))
		else $error("Pin synchroniser chain broken");

	chk_det_needs_change: assert property (@(posedge CLK_I) disable iff (RESET_I)
		((det & ~(st_r.sync2 ^ st_r.prev)) == 16'h0000))
		else $error("Edge reported on a steady pin");

	chk_rise_decode: assert property (@(posedge CLK_I) disable iff (RESET_I)
		(st_r.sense[0 +: geei_pkg::SEL_W] == geei_pkg::SEL_RISE)
		|-> (det[0] == (st_r.sync2[0] && !st_r.prev[0])))
		else $error("Rising selector decoded wrongly");

	chk_fall_decode: assert property (@(posedge CLK_I) disable iff (RESET_I)
		(st_r.sense[0 +: geei_pkg::SEL_W] == geei_pkg::SEL_FALL)
		|-> (det[0] == (!st_r.sync2[0] && st_r.prev[0])))
		else $error("Falling selector decoded wrongly");

	chk_both_decode: assert property (@(posedge CLK_I) disable iff (RESET_I)
		(st_r.sense[0 +: geei_pkg::SEL_W] == geei_pkg::SEL_BOTH)
		|-> (det[0] == (st_r.sync2[0] != st_r.prev[0])))
		else $error("Both-edge selector decoded wrongly");

	// ----------------------------------------
	// Checks: register writes
	// ----------------------------------------
	chk_mask_write: assert property (@(posedge CLK_I) disable iff (RESET_I)
		(REG_WE_I && REG_ADDR_I == geei_pkg::OFS_IRQ_MASK_LOW_BANK)
		|=> (st_r.mask[7:0] == $past(REG_WDATA_I)))
		else $error("Low mask write did not land");

	chk_select_map_hi: assert property (@(posedge CLK_I) disable iff (RESET_I)
		(REG_WE_I && REG_ADDR_I == geei_pkg::OFS_EDGE_SELECT_PINS_15_12)
		|=> (st_r.sense[31:24] == $past(REG_WDATA_I)))
		else $error("Pins 15 to 12 selector mapping wrong");

	chk_select_map_mid: assert property (@(posedge CLK_I) disable iff (RESET_I)
		(REG_WE_I && REG_ADDR_I == geei_pkg::OFS_EDGE_SELECT_PINS_11_8)
		|=> (st_r.sense[23:16] == $past(REG_WDATA_I)))
		else $error("Pins 11 to 8 selector mapping wrong");

	chk_select_map_lo: assert property (@(posedge CLK_I) disable iff (RESET_I)
		(REG_WE_I && REG_ADDR_I == geei_pkg::OFS_EDGE_SELECT_PINS_3_0)
		|=> (st_r.sense[7:0] == $past(REG_WDATA_I)))
		else $error("Pins 3 to 0 selector mapping wrong");

	chk_flag_w1c_high: assert property (@(posedge CLK_I) disable iff (RESET_I)
		(REG_WE_I && REG_ADDR_I == geei_pkg::OFS_EVENT_FLAGS_HIGH_BANK && det == 16'h0000)
		|=> ((st_r.evt[15:8] & $past(REG_WDATA_I)) == 8'h00 && (st_r.src[15:8] & $past(REG_WDATA_I)) == 8'h00))
		else $error("High flag write of one did not clear flag and source");

	chk_source_w1c_high: assert property (@(posedge CLK_I) disable iff (RESET_I)
		(REG_WE_I && REG_ADDR_I == geei_pkg::OFS_IRQ_SOURCE_HIGH_BANK && det == 16'h0000)
		|=> ((st_r.src[15:8] & $past(REG_WDATA_I)) == 8'h00 && (st_r.evt[15:8] & $past(REG_WDATA_I)) == 8'h00))
		else $error("High source write of one did not clear source and flag");

	chk_select_keeps_src: assert property (@(posedge CLK_I) disable iff (RESET_I)
		(REG_WE_I && REG_ADDR_I == geei_pkg::OFS_EDGE_SELECT_PINS_3_0 && det == 16'h0000)
		|=> (st_r.src == $past(st_r.src)))
		else $error("Selector write disturbed source bits");

	chk_select_same_flag: assert property (@(posedge CLK_I) disable iff (RESET_I)
		(REG_WE_I && REG_ADDR_I == geei_pkg::OFS_EDGE_SELECT_PINS_3_0 && det == 16'h0000
		&& REG_WDATA_I[0 +: geei_pkg::SEL_W] == st_r.sense[0 +: geei_pkg::SEL_W]) |=> (st_r.evt[0] == $past(st_r.evt[0])))
		else $error("Unchanged selector cleared the event flag");

	// ----------------------------------------
	// Checks: read port and interrupt
	// ----------------------------------------
	chk_read_source: assert property (@(posedge CLK_I) disable iff (RESET_I)
		($past(REG_ADDR_I) == geei_pkg::OFS_IRQ_SOURCE_LOW_BANK) |-> (REG_RDATA_O == $past(st_r.src[7:0])))
		else $error("Low source read returned wrong data");

	chk_read_flags: assert property (@(posedge CLK_I) disable iff (RESET_I)
		($past(REG_ADDR_I) == geei_pkg::OFS_EVENT_FLAGS_HIGH_BANK) |-> (REG_RDATA_O == $past(st_r.evt[15:8])))
		else $error("High flag read returned wrong data");

	chk_irq_assert: assert property (@(posedge CLK_I) disable iff (RESET_I)
		((det & ~st_r.mask) != 16'h0000) |=> !IRQ_OUT_N_O)
		else $error("Unmasked edge did not pull the interrupt low");

	chk_irq_hold: assert property (@(posedge CLK_I) disable iff (RESET_I)
		(!IRQ_OUT_N_O && !REG_WE_I) |=> !IRQ_OUT_N_O)
		else $error("Interrupt released without a clearing write");

endmodule : geei_top

// ==== testbench/geei_host_model.sv ====
`timescale 1ns/10ps
// ----------------------------------------
// Host side of the register port
// ----------------------------------------
module geei_host_model (
	input wire logic clk_i,
	output logic [7:0] addr_o,
	output logic [7:0] wdata_o,
	output logic we_o,
	output logic rv_o
);
	initial begin
		addr_o = 8'h00;
		wdata_o = 8'h00;
		we_o = 1'b0;
		rv_o = 1'b0;
	end
	// One strobe cycle, then stale data is scrambled
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		we_o <= 1'b1;
		@(posedge clk_i);
		we_o <= 1'b0;
		wdata_o <= ~d;
	endtask : wr
	// Data stands one edge after the address edge
	task automatic rd(input logic [7:0] a);
		@(posedge clk_i);
		addr_o <= a;
		@(posedge clk_i);
		rv_o <= 1'b1;
		@(posedge clk_i);
		rv_o <= 1'b0;
	endtask : rd
endmodule : geei_host_model

// ==== testbench/tb.sv ====
`timescale 1ns/10ps
module tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [15:0] io = 16'h0000;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic we;
	logic rv;
	logic irq_n;
	logic [8:0] expq[$];
	logic [31:0] sel;
	logic [15:0] msk;
	logic [15:0] evt;
	logic [15:0] src;
	logic [15:0] pv;
	logic [15:0] nv;
	int fail_count = 0;
	int n_checks = 0;
	int bmap[4] = '{3, 1, 2, 0};

	always #20 clk = ~clk;

	geei_top u_geei_top (.CLK_I(clk), .RESET_I(rst), .IO_I(io), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
		.REG_WE_I(we), .REG_RDATA_O(rdata), .IRQ_OUT_N_O(irq_n));
	geei_host_model u_geei_host_model (.clk_i(clk), .addr_o(addr), .wdata_o(wdata), .we_o(we), .rv_o(rv));

	task automatic check(input string what, input logic [8:0] exp, input logic [8:0] seen);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic final_report;
		$display("Checks %0d, mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : final_report

	task automatic w(input logic [7:0] a, input logic [7:0] d);
		u_geei_host_model.wr(a, d);
	endtask : w

	// Note interrupt level and data, then read
	task automatic rx(input logic [7:0] a, input logic [7:0] d);
		expq.push_back({(src == 16'h0000) ? 1'b1 : 1'b0, d});
		u_geei_host_model.rd(a);
	endtask : rx

	// ----------------------------------------
	// Read monitor
	// ----------------------------------------
	always @(posedge clk) begin
		if (rv === 1'b1) begin
			if (expq.size() > 0) check("irq_rdata", expq.pop_front(), {irq_n, rdata});
			else check("extra_read", 9'h000, 9'h1ff);
		end
	end

	initial begin
		#400000;
		fail_count++;
		final_report();
	end

	initial begin
		void'($urandom(96402));
		sel = 32'h0;
		msk = 16'hffff;
		evt = 16'h0;
		src = 16'h0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rx(8'h08, 8'hff);
		rx(8'h09, 8'hff);
		rx(8'h0e, 8'h00);
		rx(8'h07, 8'h00);
		for (int i = 0; i < 12; i++) begin
			msk = 16'($urandom());
			sel = $urandom();
			nv = 16'($urandom());
			w(8'h08, msk[15:8]);
			w(8'h09, msk[7:0]);
			for (int k = 0; k < 4; k++) w(8'(10 + k), sel[bmap[k]*8 +: 8]);
			w(i[0] ? 8'h0e : 8'h10, 8'hff);
			w(i[0] ? 8'h0f : 8'h11, 8'hff);
			evt = 16'h0;
			src = 16'h0;
			for (int k = 0; k < 4; k++) rx(8'(10 + k), sel[bmap[k]*8 +: 8]);
			rx(8'h08, msk[15:8]);
			pv = io;
			io <= nv;
			@(posedge clk);
			w(i[0] ? 8'h0f : 8'h11, 8'hff);
			repeat (3) @(posedge clk);
			for (int p = 0; p < 16; p++) evt[p] = (sel[2*p] & nv[p] & ~pv[p]) | (sel[2*p+1] & ~nv[p] & pv[p]);
			src = evt & ~msk;
			rx(8'h10, evt[15:8]);
			rx(8'h11, evt[7:0]);
			rx(8'h0e, src[15:8]);
			rx(8'h0f, src[7:0]);
			w(8'h0d, ~sel[7:0]);
			evt[3:0] = 4'h0;
			rx(8'h11, evt[7:0]);
			rx(8'h0f, src[7:0]);
			w(8'h0f, 8'hff);
			evt[7:0] = 8'h00;
			src[7:0] = 8'h00;
			rx(8'h0e, src[15:8]);
			rx(8'h11, 8'h00);
		end
		final_report();
	end
endmodule : tb
